// ### src/mms_device.sv
// Purpose: Management slave end: frame decoder and 32-entry register bank.
// Assumes: Link clock and data arrive asynchronously and are synchronised here.
// Notes:   Own address is strapped at reset into the extended control register.
`timescale 1ns/100ps
module mms_device #(
  parameter logic [15:0] ID_HIGH = 16'h1234,  // Arbitrary identifier value.
  parameter logic [15:0] ID_LOW  = 16'h5678   // Arbitrary identifier value.
) (
  mms_mgmt_if.dev                 mgmt,
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic [4:0]         phy_addr_strap,
  output logic [15:0]             control_reg,
  output logic [15:0]             ext_control_reg,
  output logic                    frame_busy
);
  import mms_pkg::*;

  function automatic logic implemented(input logic [4:0] idx);
    implemented = (idx <= MMS_REG_LPN) || (idx >= MMS_REG_EXT && idx <= MMS_REG_EXT2);
  endfunction : implemented

  // Bits that software may always write.
  function automatic logic [15:0] write_mask(input logic [4:0] idx);
    case (idx)
      MMS_REG_STAT, MMS_REG_IDH, MMS_REG_IDL, MMS_REG_LPA, MMS_REG_LPN:
        write_mask = MMS_NO_BITS;
      default:
        write_mask = MMS_ALL_BITS;
    endcase
  endfunction : write_mask

  // Bits writable only while the override bit is set.
  function automatic logic [15:0] protected_mask(input logic [4:0] idx);
    protected_mask = (idx == MMS_REG_STAT) ? (16'h0001 << MMS_SKIP_BIT) : MMS_NO_BITS;
  endfunction : protected_mask

  logic        mdc_s1_q, mdc_s2_q, mdc_s3_q;
  logic        mdio_s1_q, mdio_s2_q;
  logic        rise;
  logic        bit_in;
  mms_state_t  state_q;
  logic [5:0]  cnt_q;
  logic [11:0] hdr_q;
  logic [15:0] shift_q;
  logic        is_read_q;
  logic        is_write_q;
  logic        dout_q;
  logic        doe_q;
  logic [15:0] regs_q [0:31];
  logic        wr_fire;
  logic [4:0]  wr_idx;
  logic [15:0] wr_val;
  logic [15:0] wr_mask;
  logic        skip_en;
  logic        override;
  logic [4:0]  own_addr;
  logic [1:0]  hdr_op;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mdc_s1_q  <= 1'b0;
      mdc_s2_q  <= 1'b0;
      mdc_s3_q  <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q  <= mgmt.mdc;
      mdc_s2_q  <= mdc_s1_q;
      mdc_s3_q  <= mdc_s2_q;
      mdio_s1_q <= mgmt.mdio;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  assign rise     = mdc_s2_q & ~mdc_s3_q;
  assign bit_in   = mdio_s2_q;
  assign skip_en  = regs_q[MMS_REG_STAT][MMS_SKIP_BIT];
  assign override = regs_q[MMS_REG_EXT][MMS_OVR_BIT];
  assign own_addr = regs_q[MMS_REG_EXT][MMS_PHYAD_LSB +: 5];
  assign hdr_op   = hdr_q[10:9];

  // Frame decoder: every decision is taken on a sampled rising edge.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q    <= MMS_PRE;
      cnt_q      <= 6'h00;
      hdr_q      <= 12'h000;
      is_read_q  <= 1'b0;
      is_write_q <= 1'b0;
    end else if (rise) begin
      case (state_q)
        MMS_PRE: begin
          if (bit_in) begin
            if (cnt_q != 6'(MMS_PRE_BITS)) begin
              cnt_q <= cnt_q + 6'h01;
            end
          end else if (cnt_q == 6'(MMS_PRE_BITS) || skip_en) begin
            state_q <= MMS_SFD;
          end else begin
            cnt_q <= 6'h00;
          end
        end
        MMS_SFD: begin
          cnt_q   <= 6'h00;
          state_q <= bit_in ? MMS_HDR : MMS_PRE;
        end
        MMS_HDR: begin
          hdr_q <= {hdr_q[10:0], bit_in};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'(MMS_HDR_BITS - 1)) begin
            cnt_q   <= 6'h00;
            state_q <= MMS_TA;
            // Invalid opcodes or another address leave both flags low.
            is_read_q  <= (hdr_op == MMS_OP_READ) && (hdr_q[8:4] == own_addr);
            is_write_q <= (hdr_op == MMS_OP_WRITE) && (hdr_q[8:4] == own_addr);
          end
        end
        MMS_TA: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'h01) begin
            cnt_q   <= 6'h00;
            state_q <= MMS_DATA;
          end
        end
        MMS_DATA: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'(MMS_DATA_BITS - 1)) begin
            cnt_q      <= 6'h00;
            state_q    <= MMS_PRE;
            is_read_q  <= 1'b0;
            is_write_q <= 1'b0;
          end
        end
        default: begin
          state_q <= MMS_PRE;
          cnt_q   <= 6'h00;
        end
      endcase
    end
  end

  // Read path: the pin changes only in the cycle that follows a sampled rise.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dout_q  <= 1'b0;
      doe_q   <= 1'b0;
      shift_q <= 16'h0000;
    end else if (rise) begin
      if (state_q == MMS_TA && is_read_q && cnt_q == 6'h00) begin
        doe_q  <= 1'b1;
        dout_q <= 1'b0;
        shift_q <= implemented(hdr_q[4:0]) ? regs_q[hdr_q[4:0]] : MMS_UNIMPL;
      end else if (state_q == MMS_TA && is_read_q) begin
        dout_q  <= shift_q[15];
        shift_q <= {shift_q[14:0], 1'b0};
      end else if (state_q == MMS_DATA && is_read_q && cnt_q != 6'(MMS_DATA_BITS - 1)) begin
        dout_q  <= shift_q[15];
        shift_q <= {shift_q[14:0], 1'b0};
      end else if (state_q == MMS_DATA && is_write_q) begin
        shift_q <= {shift_q[14:0], bit_in};
      end else begin
        doe_q  <= 1'b0;
        dout_q <= 1'b0;
      end
    end
  end

  assign wr_fire = rise && state_q == MMS_DATA && is_write_q && cnt_q == 6'(MMS_DATA_BITS - 1);
  assign wr_idx  = hdr_q[4:0];
  assign wr_val  = {shift_q[14:0], bit_in};
  assign wr_mask = write_mask(wr_idx) | (override ? protected_mask(wr_idx) : MMS_NO_BITS);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= MMS_REG_RESET;
      end
      regs_q[MMS_REG_IDH] <= ID_HIGH;
      regs_q[MMS_REG_IDL] <= ID_LOW;
      regs_q[MMS_REG_EXT][MMS_PHYAD_LSB +: 5] <= phy_addr_strap;
    end else if (wr_fire && implemented(wr_idx)) begin
      regs_q[wr_idx] <= (regs_q[wr_idx] & ~wr_mask) | (wr_val & wr_mask);
      if (wr_idx != MMS_REG_EXT) begin
        regs_q[MMS_REG_EXT][MMS_OVR_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_busy <= 1'b0;
    end else begin
      frame_busy <= (state_q != MMS_PRE);
    end
  end

  assign control_reg      = regs_q[MMS_REG_CTRL];
  assign ext_control_reg  = regs_q[MMS_REG_EXT];
  assign mgmt.mdio_dev_o  = dout_q;
  assign mgmt.mdio_dev_oe = doe_q;
endmodule : mms_device

// ### src/mms_host.sv
// Purpose: Station controller end: builds frames from software commands.
// Assumes: Software port with one-cycle read latency; no waits.
// Notes:   The link clock is divided from ref_clk and idles low.
`timescale 1ns/100ps
module mms_host (
  mms_mgmt_if.host                mgmt,
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic [1:0]         addr,
  input  wire logic [15:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [15:0]             rdata
);
  import mms_pkg::*;

  logic [63:0] frame_q;
  logic [5:0]  idx_q;
  logic [3:0]  phase_q;
  logic        busy_q;
  logic        read_q;
  logic        mdc_q;
  logic        out_q;
  logic        oe_q;
  logic [15:0] wdata_q;
  logic [15:0] result_q;
  logic        mdio_s1_q, mdio_s2_q;
  logic        start;

  assign start = wr && addr == MMS_HOST_CMD && !busy_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdio_s1_q <= mgmt.mdio;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wdata_q <= 16'h0000;
    end else if (wr && addr == MMS_HOST_WDATA) begin
      wdata_q <= wdata;
    end
  end

  // Frame sequencer; bits change at the falling edge, the device samples on the rise.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_q   <= 1'b0;
      read_q   <= 1'b0;
      frame_q  <= 64'h0;
      idx_q    <= 6'h00;
      phase_q  <= 4'h0;
      mdc_q    <= 1'b0;
      out_q    <= 1'b1;
      oe_q     <= 1'b0;
      result_q <= 16'h0000;
    end else if (start) begin
      busy_q  <= 1'b1;
      mdc_q   <= 1'b0;
      read_q  <= wdata[MMS_CMD_RD_BIT];
      frame_q <= {32'hFFFF_FFFF, 2'h1,
                  wdata[MMS_CMD_RD_BIT] ? MMS_OP_READ : MMS_OP_WRITE,
                  wdata[MMS_CMD_PHY_LSB +: 5], wdata[MMS_CMD_REG_LSB +: 5],
                  2'h2, wdata_q};
      idx_q   <= wdata[MMS_CMD_NOPRE_BIT] ? 6'(MMS_PRE_BITS) : 6'h00;
      phase_q <= 4'h0;
    end else if (busy_q) begin
      phase_q <= phase_q + 4'h1;
      if (phase_q == 4'h0) begin
        mdc_q <= 1'b0;
        out_q <= frame_q[6'(MMS_FRAME_BITS - 1) - idx_q];
        oe_q  <= !(read_q && idx_q >= 6'd46);
      end
      if (phase_q == 4'(MMS_MDC_HALF)) begin
        mdc_q <= 1'b1;
        if (read_q && idx_q >= 6'd48) begin
          result_q <= {result_q[14:0], mdio_s2_q};
        end
      end
      if (phase_q == 4'(2 * MMS_MDC_HALF - 1)) begin
        phase_q <= 4'h0;
        idx_q   <= idx_q + 6'h01;
        if (idx_q == 6'(MMS_FRAME_BITS - 1)) begin
          busy_q <= 1'b0;
          oe_q   <= 1'b0;
          out_q  <= 1'b1;
        end
      end
    end else begin
      // The last high phase ends one cycle after the frame, as long as every other one.
      mdc_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        MMS_HOST_WDATA: rdata <= wdata_q;
        MMS_HOST_RDATA: rdata <= result_q;
        MMS_HOST_STAT:  rdata <= {15'h0000, busy_q};
        default:        rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  assign mgmt.mdc          = mdc_q;
  assign mgmt.mdio_host_o  = out_q;
  assign mgmt.mdio_host_oe = oe_q;
endmodule : mms_host

// ### src/mms_mgmt_if.sv
// Purpose: Two-wire management link between controller and device.
// Assumes: The shared data line has a pull-up.
// Notes:   The line level is resolved here from both output enables.
`timescale 1ns/100ps
interface mms_mgmt_if;
  logic mdc;
  logic mdio_host_o;
  logic mdio_host_oe;
  logic mdio_dev_o;
  logic mdio_dev_oe;
  logic mdio;

  assign mdio = mdio_host_oe ? mdio_host_o : (mdio_dev_oe ? mdio_dev_o : 1'b1);

  modport dev (input mdc, input mdio, output mdio_dev_o, output mdio_dev_oe);
  modport host (output mdc, output mdio_host_o, output mdio_host_oe, input mdio);
endinterface : mms_mgmt_if

// ### src/mms_pkg.sv
// Purpose: Shared constants for the serial management slave and its controller.
// Assumes: Register words are 16 bits; frames carry 5-bit addresses.
// Notes:   Register indices double as the frame register address.
package mms_pkg;
  localparam int          MMS_PRE_BITS   = 32;
  localparam int          MMS_HDR_BITS   = 12;
  localparam int          MMS_DATA_BITS  = 16;
  localparam logic [1:0]  MMS_OP_READ    = 2'h2;
  localparam logic [1:0]  MMS_OP_WRITE   = 2'h1;
  localparam logic [4:0]  MMS_REG_CTRL   = 5'h00;
  localparam logic [4:0]  MMS_REG_STAT   = 5'h01;
  localparam logic [4:0]  MMS_REG_IDH    = 5'h02;
  localparam logic [4:0]  MMS_REG_IDL    = 5'h03;
  localparam logic [4:0]  MMS_REG_ANA    = 5'h04;
  localparam logic [4:0]  MMS_REG_LPA    = 5'h05;
  localparam logic [4:0]  MMS_REG_ANX    = 5'h06;
  localparam logic [4:0]  MMS_REG_NPT    = 5'h07;
  localparam logic [4:0]  MMS_REG_LPN    = 5'h08;
  localparam logic [4:0]  MMS_REG_EXT    = 5'h10;
  localparam logic [4:0]  MMS_REG_DST    = 5'h11;
  localparam logic [4:0]  MMS_REG_TEN    = 5'h12;
  localparam logic [4:0]  MMS_REG_EXT2   = 5'h13;
  localparam int          MMS_SKIP_BIT   = 6;
  localparam int          MMS_OVR_BIT    = 15;
  localparam int          MMS_PHYAD_LSB  = 6;
  localparam logic [15:0] MMS_REG_RESET  = 16'h0000;
  localparam logic [15:0] MMS_UNIMPL     = 16'hFFFF;
  localparam logic [15:0] MMS_ALL_BITS   = 16'hFFFF;
  localparam logic [15:0] MMS_NO_BITS    = 16'h0000;
  // Controller registers on its software port.
  localparam logic [1:0]  MMS_HOST_CMD   = 2'h0;
  localparam logic [1:0]  MMS_HOST_WDATA = 2'h1;
  localparam logic [1:0]  MMS_HOST_RDATA = 2'h2;
  localparam logic [1:0]  MMS_HOST_STAT  = 2'h3;
  localparam int          MMS_CMD_REG_LSB = 0;
  localparam int          MMS_CMD_PHY_LSB = 5;
  localparam int          MMS_CMD_RD_BIT  = 10;
  localparam int          MMS_CMD_NOPRE_BIT = 11;
  // Link clock: 48 ns period at a 4 ns system clock.
  localparam int          MMS_CLK_NS     = 4;
  localparam int          MMS_MDC_NS     = 48;
  localparam int          MMS_MDC_HALF   = MMS_MDC_NS / MMS_CLK_NS / 2;
  localparam int          MMS_FRAME_BITS = 64;
  typedef enum logic [2:0] {
    MMS_PRE  = 3'h0,
    MMS_SFD  = 3'h1,
    MMS_HDR  = 3'h2,
    MMS_TA   = 3'h3,
    MMS_DATA = 3'h4
  } mms_state_t;
endpackage : mms_pkg

// ### test/mdio_management_slave_tb.sv
// Purpose: Self-checking bench for the controller and device joined by the link.
// Assumes: Frames are issued through the controller's software port.
// Notes:   A shadow register model works out the expected value of every read that the device answers.
`timescale 1ns/100ps
module mdio_management_slave_tb;
  import mms_pkg::*;
  localparam logic [15:0] ID_H = 16'h2a51;  // Arbitrary identifier value.
  localparam logic [15:0] ID_L = 16'h0c3e;  // Arbitrary identifier value.
  logic        ref_clk;
  logic        reset;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        wr;
  logic        rd;
  logic [15:0] control_reg;
  logic [15:0] ext_control_reg;
  logic [4:0]  strap;
  logic [4:0]  ra;
  logic [15:0] q;
  logic [15:0] dev_bits;
  logic        mdc_q;
  logic        dev_busy;
  logic [15:0] mdl [32];
  integer      seed = 4;
  int          failures;
  int          checks_done;
  int          i;

  mms_mgmt_if u_mms_mgmt_if ();
  mms_device #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) u_mms_device (.mgmt(u_mms_mgmt_if.dev),
    .ref_clk(ref_clk), .reset(reset), .phy_addr_strap(strap), .control_reg(control_reg),
    .ext_control_reg(ext_control_reg), .frame_busy(dev_busy));
  mms_host u_mms_host (.mgmt(u_mms_mgmt_if.host), .ref_clk(ref_clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  mms_link_properties u_mms_link_properties (.ref_clk(ref_clk), .reset(reset),
    .mdc(u_mms_mgmt_if.mdc), .mdio_host_o(u_mms_mgmt_if.mdio_host_o),
    .mdio_host_oe(u_mms_mgmt_if.mdio_host_oe), .mdio_dev_o(u_mms_mgmt_if.mdio_dev_o),
    .mdio_dev_oe(u_mms_mgmt_if.mdio_dev_oe), .mdio(u_mms_mgmt_if.mdio));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Captures what the device puts on the line at each link clock rise.
  always @(posedge ref_clk) begin
    if (reset) begin
      mdc_q    <= 1'b0;
      dev_bits <= 16'h0000;
    end else begin
      mdc_q <= u_mms_mgmt_if.mdc;
      if (u_mms_mgmt_if.mdc && !mdc_q && u_mms_mgmt_if.mdio_dev_oe) begin
        dev_bits <= {dev_bits[14:0], u_mms_mgmt_if.mdio};
      end
    end
  end

  function automatic logic impl(input logic [4:0] r);
    return r <= 5'h08 || (r >= 5'h10 && r <= 5'h13);
  endfunction : impl

  function automatic logic [15:0] exp_rd(input logic [4:0] r);
    return impl(r) ? mdl[r] : MMS_UNIMPL;
  endfunction : exp_rd

  function automatic void model_wr(input logic [4:0] r, input logic [15:0] d);
    if (!impl(r)) return;
    if (r == MMS_REG_STAT && mdl[MMS_REG_EXT][MMS_OVR_BIT]) mdl[r][MMS_SKIP_BIT] = d[MMS_SKIP_BIT];
    if (!(r inside {MMS_REG_STAT, MMS_REG_IDH, MMS_REG_IDL, MMS_REG_LPA, MMS_REG_LPN})) mdl[r] = d;
    if (r != MMS_REG_EXT) mdl[MMS_REG_EXT][MMS_OVR_BIT] = 1'b0;
  endfunction : model_wr

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic sw_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : sw_wr

  task automatic sw_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : sw_rd

  task automatic frame(input logic rd_op, input logic [4:0] phy, input logic [4:0] r,
                       input logic nop, input logic [15:0] d, output logic [15:0] res);
    logic [15:0] s;
    int n;
    sw_wr(MMS_HOST_WDATA, d);
    sw_wr(MMS_HOST_CMD, {4'h0, nop, rd_op, phy, r});
    s = 16'h0001;
    for (n = 0; n < 1000 && s[0] !== 1'b0; n++) sw_rd(MMS_HOST_STAT, s);
    if (s[0] !== 1'b0) begin
      failures++;
      finish_test();
    end
    sw_rd(MMS_HOST_RDATA, res);
    check("decoder idle", {15'h0000, dev_busy}, 16'h0000);
  endtask : frame

  task automatic wr_chk(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] res;
    frame(1'b0, strap, r, 1'b0, d, res);
    model_wr(r, d);
    check("control port", control_reg, mdl[MMS_REG_CTRL]);
    check("ext port", ext_control_reg, mdl[MMS_REG_EXT]);
  endtask : wr_chk

  task automatic rd_chk(input logic [4:0] r);
    logic [15:0] res;
    frame(1'b1, strap, r, 1'b0, 16'h0000, res);
    check("read data", res, exp_rd(r));
    check("wire bits", dev_bits, exp_rd(r));
  endtask : rd_chk

  initial begin
    reset = 1'b1;
    addr = 2'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    failures = 0;
    checks_done = 0;
    strap = 5'($random(seed));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (mdl[k]) mdl[k] = MMS_REG_RESET;
    mdl[MMS_REG_IDH] = ID_H;
    mdl[MMS_REG_IDL] = ID_L;
    mdl[MMS_REG_EXT] = 16'(strap) << MMS_PHYAD_LSB;
    @(posedge ref_clk);
    check("control reset", control_reg, MMS_REG_RESET);
    check("ext reset", ext_control_reg, mdl[MMS_REG_EXT]);
    for (i = 0; i < 20; i++) rd_chk(5'(i));
    $display("test reset values done");
    for (i = 0; i < 16; i++) begin
      ra = 5'($random(seed));
      if (ra == MMS_REG_EXT) ra = MMS_REG_ANA;
      wr_chk(ra, 16'($random(seed)));
      rd_chk(ra);
    end
    $display("test random access done");
    frame(1'b1, strap ^ 5'h01, MMS_REG_IDH, 1'b0, 16'h0000, q);
    check("foreign read", q, MMS_UNIMPL);
    frame(1'b0, strap ^ 5'h10, MMS_REG_ANA, 1'b0, ~mdl[MMS_REG_ANA], q);
    rd_chk(MMS_REG_ANA);
    frame(1'b1, strap, MMS_REG_IDH, 1'b1, 16'h0000, q);
    check("short frame", q, MMS_UNIMPL);
    $display("test refused frames done");
    wr_chk(MMS_REG_STAT, 16'h0040);
    wr_chk(MMS_REG_EXT, mdl[MMS_REG_EXT] | 16'h8000);
    wr_chk(MMS_REG_ANA, 16'h5a5a);
    wr_chk(MMS_REG_STAT, 16'h0040);
    rd_chk(MMS_REG_STAT);
    wr_chk(MMS_REG_EXT, mdl[MMS_REG_EXT] | 16'h8000);
    wr_chk(MMS_REG_STAT, 16'hffff);
    rd_chk(MMS_REG_STAT);
    $display("test override done");
    for (i = 0; i < 20; i++) begin
      frame(1'b1, strap, 5'(i), 1'b1, 16'h0000, q);
      check("skip read", q, exp_rd(5'(i)));
    end
    $display("test preamble skip done");
    finish_test();
  end
endmodule : mdio_management_slave_tb

// ### test/mms_link_properties.sv
// Purpose: Timing checks on the management link between the two ends.
// Assumes: One clock domain; reset is synchronous and active high.
// Notes:   Sees only the interface signals and the system clock and reset.
`timescale 1ns/100ps
module mms_link_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_host_o,
  input wire logic mdio_host_oe,
  input wire logic mdio_dev_o,
  input wire logic mdio_dev_oe,
  input wire logic mdio
);
  logic [15:0] drive_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Counts the cycles the device has held the line; a read drives 17 bit times.
  always_ff @(posedge ref_clk) begin
    if (reset || !mdio_dev_oe) begin
      drive_q <= 16'h0000;
    end else begin
      drive_q <= drive_q + 16'h0001;
    end
  end

  property p_one_driver;
    !(mdio_host_oe && mdio_dev_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive the data line");

  property p_idle_level;
    !mdio_host_oe && !mdio_dev_oe |-> mdio;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("released data line does not rest high");

  property p_quiet_after_reset;
    $fell(reset) |-> !mdio_dev_oe && !mdio_host_oe && !mdc;
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset)
    else $error("link not idle after reset");

  property p_drive_on_high;
    mdio_dev_oe && (!$past(mdio_dev_oe) || $changed(mdio_dev_o)) |-> mdc;
  endproperty
  a_drive_on_high: assert property (p_drive_on_high)
    else $error("device changed the line outside the clock high phase");

  property p_ta_zero;
    $rose(mdio_dev_oe) |-> (mdio_dev_oe && !mdio_dev_o) [*8];
  endproperty
  a_ta_zero: assert property (p_ta_zero)
    else $error("turnaround bit not a driven zero");

  property p_release_on_high;
    $fell(mdio_dev_oe) |-> mdc;
  endproperty
  a_release_on_high: assert property (p_release_on_high)
    else $error("device released the line at the wrong moment");

  property p_drive_span;
    $fell(mdio_dev_oe) |-> drive_q >= 16'd200 && drive_q <= 16'd208;
  endproperty
  a_drive_span: assert property (p_drive_span)
    else $error("device drive span is not seventeen bit times");

  property p_drive_bounded;
    drive_q <= 16'd208;
  endproperty
  a_drive_bounded: assert property (p_drive_bounded)
    else $error("device holds the line too long");

  property p_mdc_high;
    $rose(mdc) |-> mdc [*6] ##1 !mdc;
  endproperty
  a_mdc_high: assert property (p_mdc_high)
    else $error("link clock high phase is not six cycles");
endmodule : mms_link_properties
